// ---- hw/audio_tx_pkg.sv ----
// audio_tx_pkg: register map, field layout, framing codes and states
// assumes: shared by the serial audio source and its slot memory
package audio_tx_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] FSLEN_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] FRAMES_OFS = 8'h14;
  localparam logic [1:0] TAB_PAGE = 2'h1; // haddr[7:6] of slot table 0x40..0x7c

  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FMT_LSB = 1;
  localparam int CTRL_RATE_LSB = 3;

  // status and mask bits
  localparam int STS_FRAME = 0;
  localparam int STS_CFGERR = 1;
  localparam int STS_RUN = 2;

  // format codes of format_select_field
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_TDM4 = 2'h1;
  localparam logic [1:0] FMT_TDM8 = 2'h2;
  localparam logic [1:0] FMT_TDM16 = 2'h3;

  // codes of sample_rate_field
  localparam logic [2:0] RATE_44K1 = 3'h0;
  localparam logic [2:0] RATE_48K = 3'h1;
  localparam logic [2:0] RATE_96K = 3'h2;
  localparam logic [2:0] RATE_192K = 3'h3;

  // framing figures
  localparam logic [9:0] FRAME_BITS_I2S = 10'h040; // 64 bit clocks per frame
  localparam logic [8:0] I2S_FS_HIGH = 9'h020; // 32 bit clocks high
  localparam logic [4:0] WORD_FIRST_BIT = 5'h01; // msb one clock after word start

  // reset values and the divider floor
  localparam logic [15:0] DIV_RST = 16'h0014;
  localparam logic [15:0] DIV_MIN = 16'h0002;
  localparam logic [8:0] FSLEN_RST = 9'h001;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

endpackage

// ---- hw/slot_mem_if.sv ----
// slot_mem_if: write port and two registered read ports of the slot table
// assumes: one clock, driven by the source top and served by slot_mem
`timescale 1ns/10ps
interface slot_mem_if #(
  parameter int AW = 4,
  parameter int WIDTH = 32
);
  logic we;
  logic [AW-1:0] waddr;
  logic [WIDTH-1:0] wdata;
  logic [AW-1:0] ra_addr;
  logic [WIDTH-1:0] ra_data;
  logic [AW-1:0] rb_addr;
  logic [WIDTH-1:0] rb_data;

  modport mem (input we, waddr, wdata, ra_addr, rb_addr, output ra_data, rb_data);
  modport user (output we, waddr, wdata, ra_addr, rb_addr, input ra_data, rb_data);
endinterface

// ---- hw/slot_mem.sv ----
// slot_mem: table of slot words, one write port, two registered reads
// assumes: clk_sys_i domain; a read of a word being written sees new data
`timescale 1ns/10ps
module slot_mem import audio_tx_pkg::*; #(
  parameter int AW = 4,
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // table access
  slot_mem_if.mem port
);
  localparam int WORDS = 1 << AW;

  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] w;
    logic [WIDTH-1:0] ra;
    logic [WIDTH-1:0] rb;
  } mem_state_t;

  mem_state_t q;
  mem_state_t n;

  if (AW < 1 || AW > 8) begin : g_chk
    $error("slot_mem: AW out of range");
  end

  // write one entry, register both reads with write bypass
  always_comb begin
    n = q;
    for (int i = 0; i < WORDS; i++) begin
      if (port.we && port.waddr == AW'(i)) begin
        n.w[i] = port.wdata;
      end
    end
    n.ra = (port.we && port.waddr == port.ra_addr) ? port.wdata : q.w[port.ra_addr];
    n.rb = (port.we && port.waddr == port.rb_addr) ? port.wdata : q.w[port.rb_addr];
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign port.ra_data = q.ra;
  assign port.rb_data = q.rb;
endmodule

// ---- hw/audio_tx_source.sv ----
// audio_tx_source: serial audio source driving bit clock, frame select, data
// assumes: ahb-lite single word transfers, 125 MHz clk_sys_i, receiver on pins
//
// What this block does
// - frame select period equals one sample period; frames are whole.
// - formats i2s, tdm4 to 192k, tdm8 to 96k, tdm16 to 48k only.
// - words are two's complement, most significant bit sent first.
// - receiver format and rate fields must match the bus.
// - i2s uses 64 bit clocks per frame, two 32-bit words.
// - tdm4 uses 128 bit clocks per frame, slots 0 to 3.
// - tdm8 uses 256 bit clocks per frame, slots 0 to 7.
// - tdm16 uses 512 bit clocks per frame, slots 0 to 15.
// - data and frame select change away from the rising bit clock edge.
// - frame select high 32 clocks in i2s, 1 up to frame less one in tdm.
`timescale 1ns/10ps
module audio_tx_source import audio_tx_pkg::*; #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // serial audio pins
  output logic serial_bit_clock_pin_o,
  output logic frame_select_pin_o,
  output logic serial_audio_data_pin_o,
  // interrupt
  output logic irq_o
);

  if (DIV_W < 5 || DIV_W > 16) begin : g_chk
    $error("audio_tx_source: DIV_W must lie in 5..16");
  end

  typedef struct packed {
    run_state_t st;
    logic [DIV_W-1:0] half;
    logic [DIV_W-1:0] cnt;
    logic sck;
    logic fs;
    logic sd;
    logic [8:0] pos;
    logic [31:0] sh;
    logic en;
    logic [1:0] fmt;
    logic [2:0] rate;
    logic [8:0] fs_cfg;
    logic [1:0] fmt_s;
    logic [8:0] fs_len_s;
    logic [1:0] sts;
    logic [1:0] mask;
    logic [31:0] frames;
    logic a_wr;
    logic a_rd;
    logic [7:0] a_addr;
  } state_t;

  state_t q;
  state_t n;
  logic legal;
  logic tick;
  logic fall_w;
  logic [8:0] last_s;
  logic ev_frame;
  logic ev_err;
  logic [DIV_W-1:0] half_eff;

  slot_mem_if #(.AW(4), .WIDTH(32)) mif ();

  slot_mem #(.AW(4), .WIDTH(32)) u_mem (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .port(mif.mem)
  );

  // frame length in bit clocks for a format
  function automatic logic [9:0] frame_bits(input logic [1:0] fmt);
    frame_bits = FRAME_BITS_I2S << fmt; // 64, 128, 256, 512
  endfunction

  // frame select high length, clamped to what the format allows
  function automatic logic [8:0] fs_len(input logic [1:0] fmt, input logic [8:0] cfg);
    logic [9:0] fb;
    fb = frame_bits(fmt);
    if (fmt == FMT_I2S) begin
      fs_len = I2S_FS_HIGH;
    end else if (cfg == 9'h000) begin
      fs_len = 9'h001;
    end else if ({1'b0, cfg} >= fb) begin
      fs_len = 9'(fb - 10'h001);
    end else begin
      fs_len = cfg;
    end
  endfunction

  // format and rate pairs the receiver can serve
  assign legal = (q.rate <= RATE_192K)
    && !(q.fmt == FMT_TDM8 && q.rate == RATE_192K)
    && !(q.fmt == FMT_TDM16 && (q.rate == RATE_96K || q.rate == RATE_192K));

  // bit clock divider terms
  assign half_eff = (q.half < DIV_W'(DIV_MIN)) ? DIV_W'(DIV_MIN) : q.half;
  assign tick = (q.cnt >= half_eff - DIV_W'(1));
  assign fall_w = (q.st == ST_RUN) && tick && q.sck;
  assign last_s = 9'(frame_bits(q.fmt_s) - 10'h001);

  // memory hookup: serializer reads the word of the current slot
  assign mif.we = q.a_wr && (q.a_addr[7:6] == TAB_PAGE);
  assign mif.waddr = q.a_addr[5:2];
  assign mif.wdata = hwdata_i;
  assign mif.ra_addr = q.pos[8:5];
  assign mif.rb_addr = haddr_i[5:2];

  // next state: serializer, bus slave and status
  always_comb begin
    n = q;
    ev_frame = 1'b0;
    ev_err = 1'b0;
    case (q.st)
      ST_IDLE: begin
        n.cnt = '0;
        n.sck = 1'b0;
        n.fs = 1'b0;
        n.sd = 1'b0;
        if (q.en && legal) begin
          // first frame: frame select rises with bit 0 ahead of the first rise
          n.st = ST_RUN;
          n.pos = 9'h000;
          n.fmt_s = q.fmt;
          n.fs_len_s = fs_len(q.fmt, q.fs_cfg);
          n.fs = 1'b1;
          n.sh = '0;
          n.frames = q.frames + 32'h1;
          ev_frame = 1'b1;
        end else if (q.en) begin
          ev_err = 1'b1;
        end
      end
      ST_RUN: begin
        n.cnt = tick ? '0 : q.cnt + DIV_W'(1);
        if (tick) begin
          n.sck = !q.sck;
          // pins change only at the falling edge, half a bit before sampling
          if (q.sck) begin
            if (q.pos == last_s) begin
              if (!q.en || !legal) begin
                // stop only at a frame boundary so the last frame is whole
                n.st = ST_IDLE;
                n.pos = 9'h000;
                n.fs = 1'b0;
                n.sd = 1'b0;
                ev_err = q.en;
              end else begin
                // new frame: config taken only here keeps frame length exact
                n.pos = 9'h000;
                n.fmt_s = q.fmt;
                n.fs_len_s = fs_len(q.fmt, q.fs_cfg);
                n.fs = 1'b1;
                n.sd = q.sh[31]; // last bit of last slot
                n.sh = {q.sh[30:0], 1'b0};
                n.frames = q.frames + 32'h1;
                ev_frame = 1'b1;
              end
            end else begin
              n.pos = q.pos + 9'h001;
              n.fs = (n.pos < q.fs_len_s);
              if (n.pos[4:0] == WORD_FIRST_BIT) begin
                // msb of the next word one clock after its slot start
                n.sd = mif.ra_data[31];
                n.sh = {mif.ra_data[30:0], 1'b0};
              end else begin
                n.sd = q.sh[31];
                n.sh = {q.sh[30:0], 1'b0};
              end
            end
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // ahb address phase capture
    n.a_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    n.a_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    n.a_addr = haddr_i[7:0];

    // ahb data phase writes
    if (q.a_wr) begin
      if (q.a_addr == CTRL_OFS) begin
        n.en = hwdata_i[CTRL_EN_BIT];
        n.fmt = hwdata_i[CTRL_FMT_LSB +: 2];
        n.rate = hwdata_i[CTRL_RATE_LSB +: 3];
      end else if (q.a_addr == DIV_OFS) begin
        n.half = hwdata_i[DIV_W-1:0];
      end else if (q.a_addr == FSLEN_OFS) begin
        n.fs_cfg = hwdata_i[8:0];
      end else if (q.a_addr == STAT_OFS) begin
        n.sts = q.sts & ~hwdata_i[1:0];
      end else if (q.a_addr == MASK_OFS) begin
        n.mask = hwdata_i[1:0];
      end
    end

    // events win over a clear in the same cycle
    n.sts[STS_FRAME] = n.sts[STS_FRAME] | ev_frame;
    n.sts[STS_CFGERR] = n.sts[STS_CFGERR] | ev_err;
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.half <= DIV_W'(DIV_RST);
      q.fs_cfg <= FSLEN_RST;
      q.fs_len_s <= I2S_FS_HIGH;
    end else begin
      q <= n;
    end
  end

  // read data mux in the data phase
  always_comb begin
    hrdata_o = 32'h0;
    if (q.a_rd) begin
      if (q.a_addr == CTRL_OFS) begin
        hrdata_o = {26'h0, q.rate, q.fmt, q.en};
      end else if (q.a_addr == DIV_OFS) begin
        hrdata_o = 32'(q.half);
      end else if (q.a_addr == FSLEN_OFS) begin
        hrdata_o = {23'h0, q.fs_cfg};
      end else if (q.a_addr == STAT_OFS) begin
        hrdata_o = {29'h0, q.st == ST_RUN, q.sts};
      end else if (q.a_addr == MASK_OFS) begin
        hrdata_o = {30'h0, q.mask};
      end else if (q.a_addr == FRAMES_OFS) begin
        hrdata_o = q.frames;
      end else if (q.a_addr[7:6] == TAB_PAGE) begin
        hrdata_o = mif.rb_data;
      end
    end
  end

  // bus answer, pins and interrupt
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign serial_bit_clock_pin_o = q.sck;
  assign frame_select_pin_o = q.fs;
  assign serial_audio_data_pin_o = q.sd;
  assign irq_o = |(q.sts & q.mask);

  // checks on the driven pins
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_fs_rise_pos: assert property ($rose(frame_select_pin_o) |-> q.pos == 9'h000)
    else $error("frame select rose away from frame start");

  chk_sd_change_low: assert property (
    $changed(serial_audio_data_pin_o) |-> !serial_bit_clock_pin_o)
    else $error("data changed while bit clock high");

  chk_fs_change_low: assert property (
    $changed(frame_select_pin_o)
      |-> !serial_bit_clock_pin_o && ($past(serial_bit_clock_pin_o) || $past(q.st == ST_IDLE)))
    else $error("frame select changed outside a falling edge");

  chk_run_legal_cfg: assert property ($rose(q.st == ST_RUN) |-> $past(legal))
    else $error("started with an unsupported format and rate");

  chk_i2s_fs_high: assert property (
    (q.st == ST_RUN && q.fmt_s == FMT_I2S) |-> frame_select_pin_o == (q.pos < I2S_FS_HIGH))
    else $error("i2s frame select not high for 32 bit clocks");

  chk_tdm_fs_high: assert property (
    (q.st == ST_RUN && q.fmt_s != FMT_I2S)
      |-> frame_select_pin_o == (q.pos < q.fs_len_s) && q.fs_len_s >= 9'h001
      && q.fs_len_s <= last_s)
    else $error("tdm frame select high time out of range");

  chk_pos_in_frame: assert property ((q.st == ST_RUN) |-> q.pos <= last_s)
    else $error("bit position beyond frame length");

  chk_msb_load: assert property (
    (fall_w && q.pos[4:0] == 5'h00 && q.pos != last_s)
      |=> serial_audio_data_pin_o == $past(mif.ra_data[31]) && q.pos[4:0] == WORD_FIRST_BIT)
    else $error("word msb not sent one clock after slot start");

  chk_frame_wrap: assert property (
    (fall_w && q.pos == last_s && q.en && legal) |=> q.pos == 9'h000 && frame_select_pin_o)
    else $error("frame did not restart after its last bit");

  chk_cfg_err_flag: assert property (
    (q.st == ST_IDLE && q.en && !legal) |=> q.sts[STS_CFGERR])
    else $error("unsupported configuration not flagged");

  // frame boundaries, bit clock pacing and a quiet link between frames
  chk_idle_pins_low: assert property (
    (q.st == ST_IDLE)
      |-> !serial_bit_clock_pin_o && !frame_select_pin_o && !serial_audio_data_pin_o)
    else $error("link pins not quiet outside frames");

  chk_sck_on_tick: assert property (
    $changed(serial_bit_clock_pin_o) |-> $past(tick) && $past(q.st == ST_RUN))
    else $error("bit clock toggled off the divider tick");

  chk_fmt_at_boundary: assert property (
    (q.st == ST_RUN && !(fall_w && q.pos == last_s)) |=> $stable(q.fmt_s) && $stable(q.fs_len_s))
    else $error("format or frame select length switched inside a frame");

  chk_frame_flag_set: assert property (
    ev_frame |=> q.sts[STS_FRAME] && q.pos == 9'h000 && frame_select_pin_o)
    else $error("frame start not flagged or not at position zero");

  chk_stop_at_end: assert property (
    (fall_w && q.pos == last_s && !q.en) |=> q.st == ST_IDLE && !frame_select_pin_o)
    else $error("disabled source did not stop at the frame end");

endmodule

// ---- sim/audio_rx_model.sv ----
// audio_rx_model: behavioural serial audio receiver facing the source
// assumes: pins sampled in the clk_sys_i domain; format and slot set by the bench
`timescale 1ns/10ps
module audio_rx_model import audio_tx_pkg::*; #(
  parameter int IDLE_LIM = 200
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // serial audio pins
  input wire logic bclk_i,
  input wire logic fsel_i,
  input wire logic sdat_i,
  // settings
  input wire logic [1:0] fmt_i,
  input wire logic [3:0] slot_i,
  // observations
  output logic [23:0] word_o,
  output logic [15:0] cnt_o,
  output logic ferr_o,
  output logic [9:0] fsh_o,
  output logic standby_o
);
  logic bclk_q, fs_q, seen;
  logic [9:0] pos, hcnt, len, nx, i;
  logic [8:0] idle;
  logic [23:0] sh;

  // frame length in bit clocks for each format
  assign len = FRAME_BITS_I2S << fmt_i;

  // bit clock edge finder, frame check, slot capture and loss detection
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {bclk_q, fs_q, seen, pos, hcnt, idle, word_o, cnt_o, ferr_o, fsh_o} <= '0;
      standby_o <= 1'b1;
    end else begin
      bclk_q <= bclk_i;
      if (bclk_i && !bclk_q) begin
        // both lines taken on the rising bit clock edge
        idle <= '0;
        standby_o <= 1'b0;
        fs_q <= fsel_i;
        nx = (fsel_i && !fs_q) ? 10'h0 : pos + 10'h1;
        if (nx == 10'h0) begin
          if (seen && pos + 10'h1 != len) ferr_o <= 1'b1;
          seen <= 1'b1;
        end
        hcnt <= (nx == 10'h0) ? 10'h1 : hcnt + {9'h0, fsel_i};
        if (!fsel_i && fs_q) fsh_o <= hcnt;
        pos <= nx;
        // msb one clock after slot start; last slot ends on next frame
        i = (nx == 10'h0) ? len - 10'h1 : nx - 10'h1;
        if (i[9:5] == {1'b0, slot_i} && i[4:0] < 5'd24) begin
          sh[5'd23 - i[4:0]] = sdat_i;
        end
        if (i[9:5] == {1'b0, slot_i} && i[4:0] == 5'd31) begin
          word_o <= sh; // handed on at slot end; output group delay not modelled
          cnt_o <= cnt_o + 16'h1;
        end
      end else if (idle < IDLE_LIM) begin
        idle <= idle + 9'h1;
      end else begin
        // bit clock gone: drop to standby and forget framing
        standby_o <= 1'b1;
        {seen, fs_q} <= '0;
      end
    end
  end
endmodule

// ---- sim/testbench.sv ----
// testbench: drives the serial audio source over ahb-lite, judges the receiver model
// assumes: zero-wait slave with hready looped back from hreadyout
`timescale 1ns/10ps
module testbench import audio_tx_pkg::*; ();
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [1:0] m_fmt = 2'h0;
  logic [3:0] m_slot = 4'h0;
  logic hreadyout_o, hresp_o, irq_o, sck, fsel, sdat, ferr, standby;
  logic [31:0] hrdata_o;
  logic [23:0] rx_word;
  logic [15:0] rx_cnt;
  logic [9:0] fs_high;
  int n_mismatch = 0;
  int check_count = 0;

  // 125 MHz system clock
  always #4 clk_sys_i = ~clk_sys_i;

  audio_tx_source #(.DIV_W(16)) u_audio_tx_source (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .serial_bit_clock_pin_o(sck), .frame_select_pin_o(fsel),
    .serial_audio_data_pin_o(sdat), .irq_o(irq_o));

  audio_rx_model u_audio_rx_model (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bclk_i(sck), .fsel_i(fsel),
    .sdat_i(sdat), .fmt_i(m_fmt), .slot_i(m_slot), .word_o(rx_word), .cnt_o(rx_cnt),
    .ferr_o(ferr), .fsh_o(fs_high), .standby_o(standby));

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus phase: values taken just before the edge that sees hready high
  task automatic phase_wait(output logic [31:0] d);
    logic rdy;
    rdy = 1'b0;
    for (int n = 0; !rdy; n++) begin
      @(negedge clk_sys_i);
      d = hrdata_o;
      rdy = (hreadyout_o === 1'b1);
      @(posedge clk_sys_i);
      if (n > 100) begin
        n_mismatch++;
        stop_test();
      end
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    phase_wait(rd);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    phase_wait(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(x & m, e);
  endtask

  // pins idle and interrupt level, looked at mid-cycle
  task automatic idle_chk(input logic irq_e);
    @(negedge clk_sys_i);
    check({26'h0, hresp_o, hreadyout_o, irq_o, sck, fsel, sdat}, {26'h0, 2'b01, irq_e, 3'b0});
    @(posedge clk_sys_i);
  endtask

  function automatic logic [31:0] tw(input logic [3:0] k);
    return {k, 4'h8, 8'ha5, ~k, 4'h1, 8'hc3};
  endfunction

  task automatic wait_words(input int k);
    logic [15:0] c0;
    int n;
    c0 = rx_cnt;
    for (n = 0; rx_cnt != c0 + k[15:0] && n < 20000; n++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    if (n >= 20000) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic wait_stop();
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      ahb(1'b0, STAT_OFS, 32'h0, x);
      n++;
    end while (x[STS_RUN] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // reset values, read-only and unmapped places, table fill
  task automatic t_regs();
    logic [7:0] a [8] = '{CTRL_OFS, DIV_OFS, FSLEN_OFS, STAT_OFS, MASK_OFS,
                          FRAMES_OFS, 8'h40, 8'h20};
    logic [31:0] e [8] = '{32'h0, {16'h0, DIV_RST}, {23'h0, FSLEN_RST}, 32'h0,
                           32'h0, 32'h0, 32'h0, 32'h0};
    for (int k = 0; k < 8; k++) rdchk(a[k], '1, e[k]);
    wr(8'h20, '1);
    rdchk(8'h20, '1, 32'h0);
    wr(FRAMES_OFS, '1);
    rdchk(FRAMES_OFS, '1, 32'h0);
    wr(DIV_OFS, 32'h2);
    rdchk(DIV_OFS, 32'hffff, 32'h2);
    wr(FSLEN_OFS, 32'h5);
    for (int k = 0; k < 16; k++) wr(8'h40 + 8'(4 * k), tw(4'(k)));
    rdchk(8'h7c, '1, tw(4'hf));
  endtask

  // one format, rate and slot: run two words through and stop again
  task automatic t_format(input logic [1:0] f, input logic [2:0] r, input logic [3:0] s);
    logic [31:0] w;
    w = tw(s);
    m_fmt <= f;
    m_slot <= s;
    wr(CTRL_OFS, {26'h0, r, f, 1'b1});
    wait_words(2);
    @(negedge clk_sys_i);
    check({8'h0, rx_word}, {8'h0, w[31:8]});
    check({31'h0, ferr}, 32'h0);
    check({22'h0, fs_high}, (f == FMT_I2S) ? 32'd32 : 32'd5);
    check({31'h0, standby}, 32'h0);
    @(posedge clk_sys_i);
    rdchk(STAT_OFS, 32'h5, 32'h5);
    wr(CTRL_OFS, 32'h0);
    wait_stop();
    idle_chk(1'b0);
    repeat (250) @(posedge clk_sys_i);
    check({31'h0, standby}, 32'h1);
  endtask

  // illegal combinations raise the config error; mask and clear the interrupt
  task automatic t_illegal();
    logic [1:0] f [2] = '{FMT_TDM8, FMT_TDM16};
    logic [2:0] r [2] = '{RATE_192K, RATE_96K};
    for (int k = 0; k < 2; k++) begin
      wr(MASK_OFS, (k == 0) ? 32'h2 : 32'h0);
      wr(CTRL_OFS, {26'h0, r[k], f[k], 1'b1});
      rdchk(STAT_OFS, 32'h6, 32'h2);
      idle_chk(k == 0);
      wr(CTRL_OFS, 32'h0);
      wr(STAT_OFS, 32'h3);
      rdchk(STAT_OFS, 32'h3, 32'h0);
      idle_chk(1'b0);
    end
  endtask

  // reset in mid-frame: pins drop at once, registers return to reset values
  task automatic t_reset();
    m_fmt <= FMT_I2S;
    m_slot <= 4'h0;
    wr(CTRL_OFS, {26'h0, RATE_48K, FMT_I2S, 1'b1});
    wait_words(1);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    idle_chk(1'b0);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rdchk(CTRL_OFS, '1, 32'h0);
    rdchk(DIV_OFS, '1, {16'h0, DIV_RST});
    rdchk(STAT_OFS, '1, 32'h0);
  endtask

  // main sequence
  initial begin
    logic [2:0] r_lo [4] = '{RATE_44K1, RATE_48K, RATE_96K, RATE_48K};
    logic [2:0] r_hi [4] = '{RATE_192K, RATE_192K, RATE_96K, RATE_48K};
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_regs();
    for (int f = 0; f < 4; f++) begin
      t_format(2'(f), r_lo[f], 4'h0);
      t_format(2'(f), r_hi[f], 4'((2 << f) - 1));
    end
    t_illegal();
    t_reset();
    stop_test();
  end
endmodule
